// [pkg/nrx_consts.svh]
// register map, field positions, reset values and counts of the rx filter block
//
// Overview of operation
// RQ1: with wait bit set, anticollision ends only on a command after select or polling
// RQ2: wait bit set blocks active mode; host must not run active exchanges then
// RQ3: at 424 kbit passive, half-slot bit halves the 212 kbit slot, else equal
// RQ4: max field times four is the longest packet; longer packets are discarded
// RQ5: a zero max field accepts packets up to 256 bytes
// RQ6: at 106 kbit without sync detect, no length limit applies
// RQ7: card-mode bits 7..5 set pause decoder sensitivity
// RQ8: card-mode bits 4..3 set pause decoder time constant
// RQ9: halted at 106 kbit, only request code 52h counts as a request
// RQ10: host may set halted flag; card state machine sets it on halt
// RQ11: an rf reset clears the halted flag
// RQ12: minimum response time is seven bits plus the two-bit extra field
// RQ13: a transmit started early is held until minimum response time ends
// RQ14: a transmit after that time starts at once on correct bit phase
// RQ15: card-mode register resets to 62h, packet-limit register to 00h
// RQ16: min field times four is the shortest packet; shorter ones are discarded
// RQ17: discarded packets are not stored and raise no reception complete; code writes their bytes, up to the max limit, before discard
`ifndef NRX_CONSTS_SVH
`define NRX_CONSTS_SVH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define NRX_IDX_PLIM 8'h1b
`define NRX_IDX_CMODE 8'h1c
`define NRX_IDX_CTRL 8'h20
`define NRX_IDX_STAT 8'h21

// ----------------------------------------
// reset values and field positions
// ----------------------------------------
`define NRX_PLIM_RST 8'h00
`define NRX_CMODE_RST 8'h62
`define NRX_WAIT_SEL_BIT 7
`define NRX_HALF_SLOT_BIT 6
`define NRX_HALT_BIT 2
`define NRX_START_BIT 13

// ----------------------------------------
// protocol figures
// ----------------------------------------
`define NRX_REQ_CODE 8'h52
`define NRX_RESP_BASE_BITS 4'h7
`define NRX_ZERO_MAX_LEN 9'h100
`define NRX_LEN_SAT 9'h1ff
`define NRX_SLOT_212_CYC 16'h0400

`endif

// [pkg/nrx_pkg.sv]
// types shared by the rx filter and timing block
`default_nettype none
package nrx_pkg;
  typedef enum logic [1:0] {NRX_R106, NRX_R212, NRX_R424} nrx_rate_t;
  typedef enum logic [1:0] {NRX_AC_IDLE, NRX_AC_HUNT, NRX_AC_SEL} nrx_ac_t;

  typedef struct packed {
    logic [3:0] bits;
    logic running;
    logic elapsed;
    logic pend;
    logic [2:0] phase_cnt;
    logic go;
  } nrx_tmr_t;

  typedef struct packed {
    logic [7:0] plim;
    logic [7:0] cmode;
    logic [5:0] minq;
    logic sync_gate;
    nrx_rate_t rate;
    logic active_req;
    logic [2:0] txphase;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_idx;
    logic [31:0] rdata;
    nrx_ac_t ac;
    logic ac_done;
    logic [8:0] cnt;
    logic over;
    logic in_pkt;
    logic wr_en;
    logic [7:0] wdat;
    logic commit;
    logic discard;
    logic req_ok;
    logic [15:0] drop_cnt;
    logic [15:0] slot_cyc;
  } nrx_top_t;
endpackage
`default_nettype wire

// [src/nrx_len_check.sv]
// packet length limit check against the min and max quad fields
`timescale 1ns/100ps
`default_nettype none
`include "nrx_consts.svh"
module nrx_len_check
  import nrx_pkg::*;
(
  // length and limits
  input wire logic [8:0] len,
  input wire logic [5:0] max_q,
  input wire logic [5:0] min_q,
  input wire nrx_rate_t rate,
  input wire logic sync_gate,
  // verdict
  output logic too_long,
  output logic too_short
);
  logic gate;
  logic [8:0] max_len;
  logic [8:0] min_len;

  // slow rate without sync detect has no limits
  assign gate = (rate != NRX_R106) | sync_gate; // [RQ6]
  assign max_len = (max_q == 6'h00) ? `NRX_ZERO_MAX_LEN : {1'b0, max_q, 2'b00}; // [RQ5]
  assign min_len = {1'b0, min_q, 2'b00};
  assign too_long = gate & (len > max_len); // [RQ4]
  assign too_short = gate & (len < min_len); // [RQ16]
endmodule
`default_nettype wire

// [src/nrx_resp_timer.sv]
// minimum receive-to-transmit response timer with bit-phase launch
`timescale 1ns/100ps
`default_nettype none
`include "nrx_consts.svh"
module nrx_resp_timer
  import nrx_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // events
  input wire logic bit_tick,
  input wire logic rx_end,
  input wire logic tx_start,
  // settings
  input wire logic [1:0] extra,
  input wire logic [2:0] phase,
  // results
  output logic tx_go,
  output logic tx_pending,
  output logic resp_elapsed
);
  nrx_tmr_t s;
  nrx_tmr_t n;
  logic [3:0] target;

  assign target = `NRX_RESP_BASE_BITS + {2'b00, extra}; // [RQ12]

  always_comb begin
    n = s;
    n.go = 1'b0;
    if (bit_tick) begin
      n.phase_cnt = 3'h0;
    end else if (s.phase_cnt != 3'h7) begin
      n.phase_cnt = s.phase_cnt + 3'h1;
    end
    if (s.running && bit_tick) begin
      n.bits = s.bits + 4'h1;
      if (s.bits + 4'h1 == target) begin // [RQ12]
        n.running = 1'b0;
        n.elapsed = 1'b1;
      end
    end
    if (rx_end) begin
      n.running = 1'b1;
      n.bits = 4'h0;
      n.elapsed = 1'b0;
    end
    // held until elapsed, then launched on the chosen phase
    if (s.pend && s.elapsed && s.phase_cnt == phase) begin // [RQ13] [RQ14]
      n.go = 1'b1;
      n.pend = 1'b0;
    end
    // a new start beats the launch clear
    if (tx_start) begin
      n.pend = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '{bits: 4'h0, running: 1'b0, elapsed: 1'b1, pend: 1'b0,
             phase_cnt: 3'h0, go: 1'b0};
    end else begin
      s <= n;
    end
  end

  assign tx_go = s.go;
  assign tx_pending = s.pend;
  assign resp_elapsed = s.elapsed;

  a_no_early_go: assert property ( // [RQ13]
    @(posedge hclk) disable iff (!hresetn) s.go |-> $past(s.elapsed))
    else $error("transmit launched before minimum response time");
  a_resp_count: assert property ( // [RQ12]
    @(posedge hclk) disable iff (!hresetn)
    $rose(s.elapsed) |-> $past(bit_tick) && ($past(s.bits) == $past(target) - 4'h1))
    else $error("response time not seven plus extra bits");
  a_rx_restart: assert property ( // [RQ12]
    @(posedge hclk) disable iff (!hresetn) rx_end |=> !s.elapsed)
    else $error("response timer did not restart on receive end");
  a_go_prompt: assert property ( // [RQ14]
    @(posedge hclk) disable iff (!hresetn)
    s.pend && s.elapsed && s.phase_cnt == phase |=> s.go)
    else $error("due transmit not launched at once");
endmodule
`default_nettype wire

// [src/nrx_top.sv]
// target-side rx length filter, anticollision end, halt and response timing
`timescale 1ns/100ps
`default_nettype none
`include "nrx_consts.svh"
module nrx_top
  import nrx_pkg::*;
#(
  parameter logic [15:0] SLOT_212_CYC = `NRX_SLOT_212_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // received packet stream
  input wire logic rx_start,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_end,
  output logic rx_wr_en,
  output logic [7:0] rx_wr_data,
  output logic rx_complete,
  output logic rx_discard,
  // card state machine events
  input wire logic sel_a_ok,
  input wire logic poll_ok,
  input wire logic cmd_valid,
  input wire logic halt_enter,
  input wire logic rf_reset,
  input wire logic req_seen,
  input wire logic [7:0] req_code,
  output logic req_accept,
  output logic anticoll_busy,
  output logic anticoll_done,
  output logic active_mode_en,
  // transmit timing
  input wire logic bit_tick,
  input wire logic tx_start,
  output logic tx_go,
  // settings to the analog side
  output logic [15:0] slot_cycles,
  output logic [2:0] pause_decoder_sensitivity,
  output logic [1:0] pause_decoder_time_constant,
  output logic halted_card_flag
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  nrx_top_t s;
  nrx_top_t n;
  logic [8:0] cnt_inc;
  logic nxt_long;
  logic cur_long;
  logic cur_short;
  logic tmr_pend;
  logic tmr_elapsed;
  logic wait_sel;
  logic halted;

  assign wait_sel = s.plim[`NRX_WAIT_SEL_BIT];
  assign halted = s.cmode[`NRX_HALT_BIT];
  assign cnt_inc = (s.cnt == `NRX_LEN_SAT) ? s.cnt : s.cnt + 9'h001;

  // ----------------------------------------
  // length checks
  // ----------------------------------------
  // one check looks ahead so an overlong byte is never stored
  nrx_len_check u_next_len (
    .len(cnt_inc),
    .max_q(s.plim[5:0]),
    .min_q(s.minq),
    .rate(s.rate),
    .sync_gate(s.sync_gate),
    .too_long(nxt_long),
    .too_short()
  );

  nrx_len_check u_cur_len (
    .len(s.cnt),
    .max_q(s.plim[5:0]),
    .min_q(s.minq),
    .rate(s.rate),
    .sync_gate(s.sync_gate),
    .too_long(cur_long),
    .too_short(cur_short)
  );

  // ----------------------------------------
  // response timer
  // ----------------------------------------
  nrx_resp_timer u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .bit_tick(bit_tick),
    .rx_end(rx_end),
    .tx_start(tx_start),
    .extra(s.cmode[1:0]),
    .phase(s.txphase),
    .tx_go(tx_go),
    .tx_pending(tmr_pend),
    .resp_elapsed(tmr_elapsed)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic start_ac;
    logic rd_hit;
    start_ac = 1'b0;
    rd_hit = 1'b0;
    n = s;
    n.ac_done = 1'b0;
    n.wr_en = 1'b0;
    n.commit = 1'b0;
    n.discard = 1'b0;

    // bus data phase write
    if (s.ap_valid && s.ap_write) begin
      case (s.ap_idx)
        `NRX_IDX_PLIM: begin
          n.plim = hwdata[7:0];
        end
        `NRX_IDX_CMODE: begin
          n.cmode = hwdata[7:0]; // [RQ10]
        end
        `NRX_IDX_CTRL: begin
          n.minq = hwdata[5:0];
          n.sync_gate = hwdata[6];
          n.rate = nrx_rate_t'(hwdata[8:7]);
          n.active_req = hwdata[9];
          n.txphase = hwdata[12:10];
          start_ac = hwdata[`NRX_START_BIT];
        end
        default: begin
        end
      endcase
    end

    // hardware set wins over rf reset and host clear
    if (rf_reset) begin
      n.cmode[`NRX_HALT_BIT] = 1'b0; // [RQ11]
    end
    if (halt_enter) begin
      n.cmode[`NRX_HALT_BIT] = 1'b1; // [RQ10]
    end

    // anticollision end
    case (s.ac)
      NRX_AC_IDLE: begin
        if (start_ac) begin
          n.ac = NRX_AC_HUNT;
        end
      end
      NRX_AC_HUNT: begin
        if (sel_a_ok || poll_ok) begin
          n.ac = NRX_AC_SEL;
        end else if (cmd_valid && !wait_sel) begin // [RQ1]
          n.ac = NRX_AC_IDLE;
          n.ac_done = 1'b1;
        end
      end
      NRX_AC_SEL: begin
        if (rf_reset) begin
          n.ac = NRX_AC_HUNT;
        end else if (cmd_valid) begin // [RQ1]
          n.ac = NRX_AC_IDLE;
          n.ac_done = 1'b1;
        end
      end
      default: begin
        n.ac = NRX_AC_IDLE;
      end
    endcase

    // halted card at 106 kbit answers only the one request code
    n.req_ok = req_seen && !(halted && s.rate == NRX_R106 &&
                             req_code != `NRX_REQ_CODE); // [RQ9]

    // packet filter; an end marker on a byte cycle is ignored, the byte is counted
    if (rx_start) begin
      n.cnt = 9'h000;
      n.over = 1'b0;
      n.in_pkt = 1'b1;
    end else if (s.in_pkt && rx_byte_valid) begin
      n.cnt = cnt_inc;
      if (nxt_long || s.over) begin // [RQ4]
        n.over = 1'b1;
      end else begin
        n.wr_en = 1'b1;
        n.wdat = rx_byte;
      end
    end else if (s.in_pkt && rx_end) begin
      n.in_pkt = 1'b0;
      if (s.over || cur_long || cur_short) begin // [RQ16] [RQ17]
        n.discard = 1'b1;
        n.drop_cnt = s.drop_cnt + 16'h0001;
      end else begin
        n.commit = 1'b1;
      end
    end

    // slot length only shrinks in passive mode at the top rate
    if (s.rate == NRX_R424 && !active_mode_en &&
        s.plim[`NRX_HALF_SLOT_BIT]) begin // [RQ3]
      n.slot_cyc = {1'b0, SLOT_212_CYC[15:1]};
    end else begin
      n.slot_cyc = SLOT_212_CYC;
    end

    // address phase; read data built from post-write values
    n.ap_valid = hsel && htrans[1] && hready && (haddr[31:10] == 22'h00_0000);
    n.ap_write = hwrite;
    n.ap_idx = haddr[9:2];
    rd_hit = n.ap_valid && !hwrite;
    if (rd_hit) begin
      case (haddr[9:2])
        `NRX_IDX_PLIM: begin
          n.rdata = {24'h00_0000, n.plim};
        end
        `NRX_IDX_CMODE: begin
          n.rdata = {24'h00_0000, n.cmode};
        end
        `NRX_IDX_CTRL: begin
          n.rdata = {19'h0_0000, n.txphase, n.active_req, n.rate,
                     n.sync_gate, n.minq};
        end
        `NRX_IDX_STAT: begin
          n.rdata = {s.drop_cnt, 11'h000, tmr_elapsed, tmr_pend,
                     active_mode_en, s.ac};
        end
        default: begin
          n.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.plim <= `NRX_PLIM_RST; // [RQ15]
      s.cmode <= `NRX_CMODE_RST; // [RQ15]
      s.rate <= NRX_R106;
      s.ac <= NRX_AC_IDLE;
      s.slot_cyc <= SLOT_212_CYC;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // zero-wait slave; every access completes okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign rx_wr_en = s.wr_en;
  assign rx_wr_data = s.wdat;
  assign rx_complete = s.commit;
  assign rx_discard = s.discard;
  assign req_accept = s.req_ok;
  assign anticoll_busy = (s.ac != NRX_AC_IDLE);
  assign anticoll_done = s.ac_done;
  // active exchanges refused while waiting for selection
  assign active_mode_en = s.active_req & ~wait_sel; // [RQ2]
  assign slot_cycles = s.slot_cyc;
  assign pause_decoder_sensitivity = s.cmode[7:5]; // [RQ7]
  assign pause_decoder_time_constant = s.cmode[4:3]; // [RQ8]
  assign halted_card_flag = halted;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_select_first: assert property ( // [RQ1]
    @(posedge hclk) disable iff (!hresetn)
    s.ac_done && $past(wait_sel) |-> $past(s.ac) == NRX_AC_SEL)
    else $error("anticollision ended without selection");
  a_active_block: assert property ( // [RQ2]
    @(posedge hclk) disable iff (!hresetn) wait_sel |-> !active_mode_en)
    else $error("active mode enabled while waiting for selection");
  a_slot_half: assert property ( // [RQ3]
    @(posedge hclk) disable iff (!hresetn)
    s.rate == NRX_R424 && !active_mode_en && s.plim[6] ##1 s.rate == NRX_R424
    |-> s.slot_cyc == {1'b0, SLOT_212_CYC[15:1]})
    else $error("short slot not half of 212 slot");
  a_max_write: assert property ( // [RQ4]
    @(posedge hclk) disable iff (!hresetn) s.wr_en |-> !cur_long)
    else $error("byte beyond maximum length stored");
  a_zero_max: assert property ( // [RQ5]
    @(posedge hclk) disable iff (!hresetn)
    s.plim[5:0] == 6'h00 && s.cnt <= 9'h100 |-> !cur_long)
    else $error("zero max field rejected packet up to 256 bytes");
  a_slow_open: assert property ( // [RQ6]
    @(posedge hclk) disable iff (!hresetn)
    s.rate == NRX_R106 && !s.sync_gate |-> !cur_long && !cur_short)
    else $error("length limit applied at slow rate without sync");
  a_decoder_cfg: assert property ( // [RQ7] [RQ8]
    @(posedge hclk) disable iff (!hresetn)
    s.ap_valid && s.ap_write && s.ap_idx == `NRX_IDX_CMODE
    |=> pause_decoder_sensitivity == $past(hwdata[7:5]) &&
        pause_decoder_time_constant == $past(hwdata[4:3]))
    else $error("pause decoder settings not taken from register");
  a_halted_req: assert property ( // [RQ9]
    @(posedge hclk) disable iff (!hresetn)
    s.req_ok && $past(halted) && $past(s.rate) == NRX_R106
    |-> $past(req_code) == `NRX_REQ_CODE)
    else $error("halted card accepted a wrong request code");
  a_halt_set: assert property ( // [RQ10]
    @(posedge hclk) disable iff (!hresetn) halt_enter |=> halted)
    else $error("halt entry did not set halted flag");
  a_rf_clear: assert property ( // [RQ11]
    @(posedge hclk) disable iff (!hresetn)
    rf_reset && !halt_enter |=> !halted)
    else $error("rf reset did not clear halted flag");
  a_reset_vals: assert property ( // [RQ15]
    @(posedge hclk) $rose(hresetn) |-> s.plim == `NRX_PLIM_RST &&
    s.cmode == `NRX_CMODE_RST)
    else $error("register reset values wrong");
  a_short_drop: assert property ( // [RQ16]
    @(posedge hclk) disable iff (!hresetn)
    s.in_pkt && rx_end && !rx_start && !rx_byte_valid && cur_short
    |=> s.discard && !s.commit)
    else $error("short packet not discarded");
  a_drop_silent: assert property ( // [RQ17]
    @(posedge hclk) disable iff (!hresetn)
    s.discard |-> !s.commit && !s.wr_en)
    else $error("discarded packet signalled complete");
  a_hunt_end: assert property ( // [RQ1]
    @(posedge hclk) disable iff (!hresetn)
    s.ac == NRX_AC_HUNT && cmd_valid && !wait_sel && !sel_a_ok && !poll_ok |=> s.ac_done)
    else $error("hunt not ended by command without wait bit");
  a_long_drop: assert property ( // [RQ4]
    @(posedge hclk) disable iff (!hresetn)
    s.in_pkt && rx_end && !rx_start && !rx_byte_valid && s.over |=> s.discard)
    else $error("overlong packet not discarded");
endmodule
`default_nettype wire

// [sim/nrx_reader_model.sv]
// remote reader model: received packet stream, carrier bit ticks, requests and rf resets
`timescale 1ns/100ps
`default_nettype none
module nrx_reader_model (
  // clock
  input wire logic hclk,
  // received packet stream
  output logic rx_start,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic rx_end,
  // carrier events
  output logic bit_tick,
  output logic req_seen,
  output logic [7:0] req_code,
  output logic rf_reset
);
  int tdiv = 0;

  initial begin
    rx_start = 1'b0;
    rx_byte_valid = 1'b0;
    rx_byte = 8'h00;
    rx_end = 1'b0;
    bit_tick = 1'b0;
    req_seen = 1'b0;
    req_code = 8'h00;
    rf_reset = 1'b0;
  end

  // ----------------------------------------
  // bit ticks: carrier derived, so they run free, one every 8 cycles
  // ----------------------------------------
  always @(posedge hclk) begin
    tdiv <= (tdiv == 7) ? 0 : tdiv + 1;
    bit_tick <= (tdiv == 7);
  end

  // ----------------------------------------
  // frame tasks; idle data toggles so no stale byte looks valid
  // ----------------------------------------
  task automatic send_pkt(input int n);
    @(posedge hclk);
    rx_start <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge hclk);
      rx_start <= 1'b0;
      rx_byte_valid <= 1'b1;
      rx_byte <= i[7:0];
    end
    // end marker never shares a cycle with a byte
    @(posedge hclk);
    rx_start <= 1'b0;
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    rx_end <= 1'b1;
    @(posedge hclk);
    rx_end <= 1'b0;
  endtask

  task automatic req(input logic [7:0] code);
    @(posedge hclk);
    req_seen <= 1'b1;
    req_code <= code;
    @(posedge hclk);
    req_seen <= 1'b0;
    req_code <= ~code;
  endtask

  task automatic rf_rst();
    @(posedge hclk);
    rf_reset <= 1'b1;
    @(posedge hclk);
    rf_reset <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [sim/tb.sv]
// self-checking bench for the rx filter, halt and response timing block
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [15:0] SLOT_C = 16'h0040;
  localparam logic [31:0] PL = 32'h0000_006c;
  localparam logic [31:0] CM = 32'h0000_0070;
  localparam logic [31:0] CT = 32'h0000_0080;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic tx_start = 1'b0;
  logic [3:0] evt = 4'h0;
  logic [31:0] scratch;
  logic [7:0] last_wd;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, rx_start, rx_byte_valid, rx_end, rx_wr_en, rx_complete;
  wire logic rx_discard, req_seen, rf_reset, req_accept, anticoll_busy, anticoll_done;
  wire logic active_mode_en, bit_tick, tx_go, halted_card_flag;
  wire logic [7:0] rx_byte, rx_wr_data, req_code;
  wire logic [15:0] slot_cycles;
  wire logic [2:0] pause_decoder_sensitivity;
  wire logic [1:0] pause_decoder_time_constant;
  int err_total = 0;
  int checks_done = 0;
  int wr_n, ok_n, bad_n, done_n, acc_n, go_n, ticks, go_ticks;

  always #25 hclk = ~hclk;

  nrx_top #(.SLOT_212_CYC(SLOT_C)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rx_start(rx_start), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_end(rx_end),
    .rx_wr_en(rx_wr_en), .rx_wr_data(rx_wr_data), .rx_complete(rx_complete),
    .rx_discard(rx_discard), .sel_a_ok(evt[0]), .poll_ok(evt[1]), .cmd_valid(evt[2]),
    .halt_enter(evt[3]), .rf_reset(rf_reset), .req_seen(req_seen), .req_code(req_code),
    .req_accept(req_accept), .anticoll_busy(anticoll_busy), .anticoll_done(anticoll_done),
    .active_mode_en(active_mode_en), .bit_tick(bit_tick), .tx_start(tx_start),
    .tx_go(tx_go), .slot_cycles(slot_cycles),
    .pause_decoder_sensitivity(pause_decoder_sensitivity),
    .pause_decoder_time_constant(pause_decoder_time_constant),
    .halted_card_flag(halted_card_flag));

  nrx_reader_model rdr (.hclk(hclk), .rx_start(rx_start), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte), .rx_end(rx_end), .bit_tick(bit_tick), .req_seen(req_seen),
    .req_code(req_code), .rf_reset(rf_reset));

  // ----------------------------------------
  // event counters, sampled at the edge
  // ----------------------------------------
  always @(posedge hclk) begin
    if (tx_go === 1'b1) begin
      go_n++;
      go_ticks = ticks;
    end
    if (rx_end) ticks = 0;
    else if (bit_tick) ticks++;
    if (rx_wr_en === 1'b1) begin
      wr_n++;
      last_wd = rx_wr_data;
    end
    if (rx_complete === 1'b1) ok_n++;
    if (rx_discard === 1'b1) bad_n++;
    if (anticoll_done === 1'b1) done_n++;
    if (req_accept === 1'b1) acc_n++;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  // single transfer; each phase held until hready is sampled high
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin
      err_total++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, scratch);
  endtask

  task automatic ev(input int k);
    @(posedge hclk);
    evt[k] <= 1'b1;
    @(posedge hclk);
    evt <= 4'h0;
  endtask

  task automatic txs();
    @(posedge hclk);
    tx_start <= 1'b1;
    @(posedge hclk);
    tx_start <= 1'b0;
  endtask

  task automatic wait_go(output int n);
    int g;
    g = go_n;
    n = 0;
    while (go_n == g && n < 300) begin
      @(posedge hclk);
      #1;
      n++;
    end
    if (n >= 300) begin
      err_total++;
      end_sim();
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    bus(1'b0, PL, 32'h0000_0000, d);
    chk("plim_rst", d, 32'h0000_0000);
    bus(1'b0, CM, 32'h0000_0000, d);
    chk("cmode_rst", d, 32'h0000_0062);
    chk("sens_rst", 32'(pause_decoder_sensitivity), 32'h0000_0003);
    wr(CM, 32'h0000_00b9);
    wr(32'h0000_0010, 32'hffff_ffff);
    settle(2);
    chk("sens", 32'(pause_decoder_sensitivity), 32'h0000_0005);
    chk("tau", 32'(pause_decoder_time_constant), 32'h0000_0003);
    bus(1'b0, 32'h0000_0010, 32'h0000_0000, d);
    chk("unmapped", d, 32'h0000_0000);
    chk("hresp", 32'(hresp), 32'h0000_0000);
    wr(CM, 32'h0000_0062);
  endtask

  task automatic t_len();
    logic [15:0] ct [8] = '{16'h0080, 16'h0080, 16'h0080, 16'h0080, 16'h0081, 16'h0081,
                            16'h0000, 16'h0040};
    logic [7:0] pl [8] = '{8'h02, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h02};
    int len [8] = '{8, 9, 256, 257, 3, 4, 20, 9};
    logic ok [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 8; i++) begin
      wr(CT, 32'(ct[i]));
      wr(PL, 32'(pl[i]));
      wr_n = 0;
      ok_n = 0;
      bad_n = 0;
      rdr.send_pkt(len[i]);
      settle(3);
      chk("pkt_ok", ok_n, 32'(ok[i]));
      chk("pkt_drop", bad_n, 32'(!ok[i]));
      if (ok[i]) chk("pkt_wr", wr_n, len[i]);
      if (ok[i]) chk("last_byte", 32'(last_wd), len[i] - 1);
    end
  endtask

  task automatic t_slot();
    wr(PL, 32'h0000_0040);
    wr(CT, 32'h0000_0100);
    settle(3);
    chk("slot_half", 32'(slot_cycles), 32'(SLOT_C >> 1));
    wr(PL, 32'h0000_0000);
    settle(3);
    chk("slot_full", 32'(slot_cycles), 32'(SLOT_C));
  endtask

  task automatic t_acoll();
    wr(PL, 32'h0000_0080);
    wr(CT, 32'h0000_2080);
    settle(2);
    done_n = 0;
    chk("ac_busy", 32'(anticoll_busy), 32'h0000_0001);
    ev(2);
    settle(2);
    chk("ac_hold", done_n, 0);
    ev(0);
    ev(2);
    settle(2);
    chk("ac_sel", done_n, 1);
    chk("ac_idle", 32'(anticoll_busy), 32'h0000_0000);
    wr(CT, 32'h0000_2080);
    ev(1);
    ev(2);
    settle(2);
    chk("ac_poll", done_n, 2);
    wr(CT, 32'h0000_0280);
    settle(2);
    chk("act_block", 32'(active_mode_en), 32'h0000_0000);
    wr(PL, 32'h0000_0000);
    settle(2);
    chk("act_on", 32'(active_mode_en), 32'h0000_0001);
    wr(CT, 32'h0000_2080);
    ev(2);
    settle(2);
    chk("ac_nowait", done_n, 3);
  endtask

  task automatic t_halt();
    wr(CT, 32'h0000_0000);
    wr(CM, 32'h0000_0066);
    settle(2);
    chk("halt_host", 32'(halted_card_flag), 32'h0000_0001);
    acc_n = 0;
    rdr.req(8'h26);
    settle(2);
    chk("req_other", acc_n, 0);
    rdr.req(8'h52);
    settle(2);
    chk("req_wake", acc_n, 1);
    rdr.rf_rst();
    settle(2);
    chk("halt_clr", 32'(halted_card_flag), 32'h0000_0000);
    rdr.req(8'h26);
    settle(2);
    chk("req_free", acc_n, 2);
    ev(3);
    settle(2);
    chk("halt_fsm", 32'(halted_card_flag), 32'h0000_0001);
    rdr.rf_rst();
  endtask

  task automatic t_timer();
    int n;
    logic [31:0] d;
    for (int e = 0; e < 4; e++) begin
      wr(CM, 32'h0000_0060 | 32'(e));
      rdr.send_pkt(1);
      txs();
      wait_go(n);
      chk("resp_bits", 32'(go_ticks >= 7 + e && go_ticks <= 8 + e), 1);
    end
    // bit phase 3; timer long elapsed, so start must leave within 12 cycles
    wr(CT, 32'h0000_0c00);
    settle(120);
    txs();
    wait_go(n);
    chk("late_start", 32'(n <= 12), 1);
    bus(1'b0, 32'h0000_0084, 32'h0000_0000, d);
    chk("stat_rd", d, 32'h0004_0010);
  endtask

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_len();
    t_slot();
    t_acoll();
    t_halt();
    t_timer();
    end_sim();
  end
endmodule
`default_nettype wire
